// [design/mmc_id_regs.svh]
`ifndef MMC_ID_REGS_SVH
`define MMC_ID_REGS_SVH
// command indices used during identification
`define CMD_GO_IDLE 6'h00
`define CMD_OP_COND 6'h01
`define CMD_ALL_CID 6'h02
`define CMD_SET_RCA 6'h03
`define CMD_APP 6'h37
`define CMD_GEN 6'h38
// frame lengths in bits
`define LEN_SHORT 8'h30
`define LEN_LONG 8'h88
// operating conditions word
`define OCR_VOLT 24'hFF8000
`define OCR_BUSY_POS 31
// status word positions: bit reported for an illegal command, and the current state field
`define STAT_ILLEGAL_POS 22
`define STAT_STATE_POS 9
// link clock periods
`define NCR_CLKS 4'h2
`define NCC_CLKS 7'h08
`define NID_CLKS 7'h05
`define NCR_MAX_CLKS 7'h40
// link clock half period in clk cycles (8 -> 80 ns at 100 MHz)
`define MCLK_HALF 8
// internal power-up procedure length in clk cycles
`define POWERUP_CYC 1000
`endif

// [design/mmc_id_pkg.sv]
package mmc_id_pkg;
	// card states, gray coded along idle-ready-ident-standby
	typedef enum logic [2:0] {
		st_idle = 3'h0,
		st_ready = 3'h1,
		st_ident = 3'h3,
		st_stby = 3'h2,
		st_inactive = 3'h6
	} card_state_e;
	// host bit engine
	typedef enum logic [2:0] {
		h_idle = 3'h0,
		h_send = 3'h1,
		h_wait = 3'h3,
		h_recv = 3'h2,
		h_gap = 3'h6
	} host_phase_e;
	// host identification sequence
	typedef enum logic [1:0] {
		s_idle = 2'h0,
		s_op = 2'h1,
		s_cid = 2'h3,
		s_rca = 2'h2
	} host_seq_e;
endpackage

// [design/mmc_bus.sv]
`timescale 1ns/100ps
`default_nettype none
interface mmc_bus;
	logic mclk;
	logic cmd_h_o;
	logic cmd_h_oe_n;
	logic cmd_c_o;
	logic cmd_c_oe_n;
	logic dat_c_oe_n;
	logic cmd_line;
	// pulled-up shared line: any enabled driver at 0 pulls it low
	assign cmd_line = (cmd_h_oe_n | cmd_h_o) & (cmd_c_oe_n | cmd_c_o);
	modport host
	(
		output mclk,
		output cmd_h_o,
		output cmd_h_oe_n,
		input cmd_line
	);
	modport card
	(
		input mclk,
		input cmd_line,
		output cmd_c_o,
		output cmd_c_oe_n,
		output dat_c_oe_n
	);
endinterface
`default_nettype wire

// [design/mmc_card.sv]
// Functional notes
// - application prefix unsupported, next command unaffected
// - general data block command unsupported
// - identification uses command line only
// - host starts open drain, slow clock
// - card drives command line open drain
// - host queries conditions; responses wired-OR
// - out-of-range card goes Inactive
// - busy bit held during power-up; host repeats
// - ready cards shift identity, compare line
// - mismatch stops sending, stays Ready
// - full identity sent: Identification State
// - host assigns relative address with command 3
// - address received: Standby, ignore identification
// - Standby switches drivers to push-pull
// - host repeats while identity answers arrive
// - no start bit in 6 clocks: done
`timescale 1ns/100ps
`default_nettype none
`include "mmc_id_regs.svh"
module mmc_card
	import mmc_id_pkg::*;
#(
	parameter int POWERUP_CYC = `POWERUP_CYC
)
(
	input wire logic clk,
	input wire logic rst,
	mmc_bus.card bus,
	input wire logic [127:0] cid,
	output card_state_e state,
	output logic [15:0] rca,
	output logic illegal_cmd,
	output logic busy
);
	localparam int PW = $clog2(POWERUP_CYC + 1);

	generate
		if (POWERUP_CYC < 1)
		begin : g_chk
			$error("POWERUP_CYC must be at least 1");
		end
	endgenerate

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic m1, m2, m3, c1, c2;

	// link clock and line pass two flops before any use
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			m1 <= 1'b0;
			m2 <= 1'b0;
			m3 <= 1'b0;
			c1 <= 1'b1;
			c2 <= 1'b1;
		end
		else
		begin
			m1 <= bus.mclk;
			m2 <= m1;
			m3 <= m2;
			c1 <= bus.cmd_line;
			c2 <= c1;
		end
	end

	logic rise, fall;
	assign rise = m2 & ~m3;
	assign fall = ~m2 & m3;

	// ------------------------------------------------------------
	// command decode and response
	// ------------------------------------------------------------
	logic [PW-1:0] pwr_cnt, next_pwr_cnt;
	logic [47:0] rx_sr, next_rx_sr;
	logic [5:0] rx_cnt, next_rx_cnt;
	logic [135:0] tx_sr, next_tx_sr;
	logic [7:0] tx_cnt, next_tx_cnt;
	logic [3:0] tx_wait, next_tx_wait;
	logic drv, next_drv, bit_o, next_bit_o, resp_cid, next_resp_cid;
	card_state_e next_state;
	logic [15:0] next_rca;
	logic next_illegal;
	logic pp;

	// reserved and unsupported indices
	function automatic logic is_reserved(input logic [5:0] i);
		logic r;
		r = 1'b0;
		case (i)
			6'h05, 6'h06, 6'h08, 6'h0E, 6'h13, 6'h15, 6'h16, 6'h1F,
			6'h27, 6'h28, 6'h29: r = 1'b1;
			default: r = (i >= 6'h2B);
		endcase
		return r;
	endfunction

	assign busy = (pwr_cnt != '0);
	assign pp = (state == st_stby);

	// one process for the whole card: receive, decide, answer
	always_comb
	begin
		logic [47:0] nsr;
		logic [5:0] idx;
		logic [31:0] arg;
		logic [31:0] stat;
		nsr = {rx_sr[46:0], c2};
		idx = nsr[45:40];
		arg = nsr[39:8];
		stat = '0;
		next_pwr_cnt = busy ? pwr_cnt - 1'b1 : pwr_cnt;
		next_rx_sr = rx_sr;
		next_rx_cnt = rx_cnt;
		next_tx_sr = tx_sr;
		next_tx_cnt = tx_cnt;
		next_tx_wait = tx_wait;
		next_drv = drv;
		next_bit_o = bit_o;
		next_resp_cid = resp_cid;
		next_state = state;
		next_rca = rca;
		next_illegal = illegal_cmd;
		// listen only while not answering, so our own bits are not parsed
		if (rise && tx_cnt == 8'h00 && !drv)
		begin
			if (rx_cnt != 6'h00 || !c2)
			begin
				next_rx_sr = nsr;
				next_rx_cnt = rx_cnt + 6'h01;
			end
			if (rx_cnt == 6'(`LEN_SHORT - 8'h01))
			begin
				next_rx_cnt = 6'h00;
				// host direction bit and end bit must be one
				if (nsr[46] && nsr[0] && state != st_inactive)
				begin
					next_tx_wait = 4'h0;
					if (idx == `CMD_GO_IDLE)
					begin
						next_state = st_idle;
						next_rca = 16'h0000;
						next_illegal = 1'b0;
					end
					else if (idx == `CMD_OP_COND && state == st_idle)
					begin
						next_illegal = 1'b0;
						if (arg != 32'h0 && (arg[23:0] & `OCR_VOLT) == 24'h0)
							next_state = st_inactive;
						else
						begin
							// busy answer while power-up runs
							next_tx_sr = {2'b00, 6'h3F, ~busy, 7'h00,
								`OCR_VOLT, 7'h7F, 1'b1, 88'h0};
							next_tx_cnt = `LEN_SHORT;
							if (arg != 32'h0 && !busy)
								next_state = st_ready;
						end
					end
					else if (idx == `CMD_ALL_CID && state == st_ready)
					begin
						// identity shifted out under arbitration
						next_illegal = 1'b0;
						next_tx_sr = {2'b00, 6'h3F, cid[127:1], 1'b1};
						next_tx_cnt = `LEN_LONG;
						next_resp_cid = 1'b1;
					end
					else if (idx == `CMD_SET_RCA && state == st_ident)
					begin
						// address taken, leave identification
						next_rca = arg[31:16];
						next_state = st_stby;
						stat[`STAT_STATE_POS +: 4] = 4'h2;
						stat[`STAT_ILLEGAL_POS] = illegal_cmd;
						next_illegal = 1'b0;
						next_tx_sr = {2'b00, `CMD_SET_RCA, stat, 7'h00, 1'b1,
							88'h0};
						next_tx_cnt = `LEN_SHORT;
					end
					else if (is_reserved(idx))
					begin
						// prefix and general block command fall here too;
						// nothing is remembered, so the next command is
						// read as a standard one
						next_illegal = 1'b1;
					end
				end
			end
		end
		// response waits the minimum turnaround before driving
		if (rise && tx_cnt != 8'h00 && tx_wait != `NCR_CLKS)
			next_tx_wait = tx_wait + 4'h1;
		// lost arbitration: stop at once, stay Ready
		if (rise && drv && !pp && bit_o && !c2)
		begin
			next_drv = 1'b0;
			next_tx_cnt = 8'h00;
			next_resp_cid = 1'b0;
		end
		else if (fall && tx_cnt != 8'h00 && tx_wait == `NCR_CLKS)
		begin
			next_drv = 1'b1;
			next_bit_o = tx_sr[135];
			next_tx_sr = {tx_sr[134:0], 1'b0};
			next_tx_cnt = tx_cnt - 8'h01;
		end
		else if (fall && tx_cnt == 8'h00 && drv)
		begin
			next_drv = 1'b0;
			next_bit_o = 1'b1;
			next_resp_cid = 1'b0;
			if (resp_cid)
				next_state = st_ident;
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			pwr_cnt <= PW'(POWERUP_CYC);
			rx_sr <= '0;
			rx_cnt <= 6'h00;
			tx_sr <= '0;
			tx_cnt <= 8'h00;
			tx_wait <= 4'h0;
			drv <= 1'b0;
			bit_o <= 1'b1;
			resp_cid <= 1'b0;
			state <= st_idle;
			rca <= 16'h0000;
			illegal_cmd <= 1'b0;
		end
		else
		begin
			pwr_cnt <= next_pwr_cnt;
			rx_sr <= next_rx_sr;
			rx_cnt <= next_rx_cnt;
			tx_sr <= next_tx_sr;
			tx_cnt <= next_tx_cnt;
			tx_wait <= next_tx_wait;
			drv <= next_drv;
			bit_o <= next_bit_o;
			resp_cid <= next_resp_cid;
			state <= next_state;
			rca <= next_rca;
			illegal_cmd <= next_illegal;
		end
	end

	// ------------------------------------------------------------
	// drivers
	// ------------------------------------------------------------
	// open drain pulls low only; standby drives both levels
	assign bus.cmd_c_o = bit_o;
	assign bus.cmd_c_oe_n = ~(drv & (pp | ~bit_o));
	// data lines stay released in this mode
	assign bus.dat_c_oe_n = 1'b1;
endmodule
`default_nettype wire

// [design/mmc_host.sv]
`timescale 1ns/100ps
`default_nettype none
`include "mmc_id_regs.svh"
module mmc_host
	import mmc_id_pkg::*;
#(
	parameter int MCLK_HALF = `MCLK_HALF
)
(
	input wire logic clk,
	input wire logic rst,
	mmc_bus.host bus,
	input wire logic start,
	input wire logic [23:0] ocr_window,
	output logic running,
	output logic done,
	output logic [15:0] card_count,
	output logic [31:0] ocr_seen
);
	generate
		if (MCLK_HALF < 4 || MCLK_HALF > 255)
		begin : g_chk
			$error("MCLK_HALF must lie in 4..255");
		end
	endgenerate

	logic l1, l2;
	// returning line passes two flops
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			l1 <= 1'b1;
			l2 <= 1'b1;
		end
		else
		begin
			l1 <= bus.cmd_line;
			l2 <= l1;
		end
	end

	host_phase_e ph, next_ph;
	host_seq_e seq, next_seq;
	logic [7:0] div_cnt, next_div_cnt;
	logic mclk, next_mclk, drv, next_drv, bit_o, next_bit_o;
	logic [47:0] tx_sr, next_tx_sr;
	logic [5:0] tx_cnt, next_tx_cnt;
	logic [6:0] wcnt, next_wcnt;
	logic [135:0] rx_sr, next_rx_sr;
	logic [7:0] rx_cnt, next_rx_cnt, rx_len, next_rx_len;
	logic [15:0] rca_next, next_rca_next, next_card_count;
	logic [31:0] next_ocr_seen;
	logic next_done, rise, fall, resp, tmo;

	// the link clock is made here from clk by a divider
	assign rise = (div_cnt == 8'(MCLK_HALF - 1)) & ~mclk;
	assign fall = (div_cnt == 8'(MCLK_HALF - 1)) & mclk;

	always_comb
	begin
		logic [5:0] idx;
		logic [31:0] arg;
		logic issue;
		idx = `CMD_OP_COND;
		arg = {8'h00, ocr_window};
		issue = 1'b0;
		resp = 1'b0;
		tmo = 1'b0;
		next_div_cnt = (div_cnt == 8'(MCLK_HALF - 1)) ? 8'h00
			: div_cnt + 8'h01;
		next_mclk = (div_cnt == 8'(MCLK_HALF - 1)) ? ~mclk : mclk;
		next_ph = ph;
		next_seq = seq;
		next_drv = drv;
		next_bit_o = bit_o;
		next_tx_sr = tx_sr;
		next_tx_cnt = tx_cnt;
		next_wcnt = wcnt;
		next_rx_sr = rx_sr;
		next_rx_cnt = rx_cnt;
		next_rx_len = rx_len;
		next_rca_next = rca_next;
		next_card_count = card_count;
		next_ocr_seen = ocr_seen;
		next_done = 1'b0;
		case (ph)
			h_idle:
				if (start)
				begin
					next_seq = s_op;
					next_card_count = 16'h0000;
					next_rca_next = 16'h0001;
					issue = 1'b1;
				end
			h_send:
				if (fall)
				begin
					next_drv = (tx_cnt != 6'h00);
					next_bit_o = tx_sr[47];
					next_tx_sr = {tx_sr[46:0], 1'b1};
					next_tx_cnt = tx_cnt - 6'h01;
					if (tx_cnt == 6'h00)
					begin
						next_ph = h_wait;
						next_wcnt = 7'h00;
						next_bit_o = 1'b1;
					end
				end
			h_wait:
				if (rise)
				begin
					if (!l2)
					begin
						next_ph = h_recv;
						next_rx_sr = {rx_sr[134:0], 1'b0};
						next_rx_cnt = 8'h01;
					end
					else if (wcnt == ((seq == s_cid) ? `NID_CLKS
						: `NCR_MAX_CLKS))
						tmo = 1'b1;
					else
						next_wcnt = wcnt + 7'h01;
				end
			h_recv:
				if (rise)
				begin
					next_rx_sr = {rx_sr[134:0], l2};
					next_rx_cnt = rx_cnt + 8'h01;
					if (rx_cnt == rx_len - 8'h01)
						resp = 1'b1;
				end
			h_gap:
				if (rise)
				begin
					next_wcnt = wcnt + 7'h01;
					if (wcnt == `NCC_CLKS)
						issue = 1'b1;
				end
			default:
				next_ph = h_idle;
		endcase
		// sequence steps on each answer or timeout
		if (resp || tmo)
		begin
			next_ph = h_gap;
			next_wcnt = 7'h00;
			case (seq)
				s_op:
					if (tmo)
						next_seq = s_idle;
					else
					begin
						next_ocr_seen = rx_sr[38:7];
						// poll until busy clears
						if (rx_sr[7 + `OCR_BUSY_POS])
							next_seq = s_cid;
					end
				s_cid:
					// an answer means one card won, keep going
					next_seq = tmo ? s_idle : s_rca;
				s_rca:
				begin
					next_seq = s_cid;
					next_card_count = card_count + 16'h0001;
					next_rca_next = rca_next + 16'h0001;
				end
				default:
					next_seq = s_idle;
			endcase
			if (next_seq == s_idle)
			begin
				next_ph = h_idle;
				next_done = 1'b1;
			end
		end
		if (issue)
		begin
			if (next_seq == s_cid)
			begin
				idx = `CMD_ALL_CID;
				arg = 32'h0;
			end
			else if (next_seq == s_rca)
			begin
				idx = `CMD_SET_RCA;
				arg = {rca_next, 16'h0000};
			end
			next_tx_sr = {1'b0, 1'b1, idx, arg, 7'h00, 1'b1};
			next_tx_cnt = 6'(`LEN_SHORT);
			next_rx_len = (next_seq == s_cid) ? `LEN_LONG : `LEN_SHORT;
			next_ph = h_send;
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ph <= h_idle;
			seq <= s_idle;
			div_cnt <= 8'h00;
			mclk <= 1'b0;
			drv <= 1'b0;
			bit_o <= 1'b1;
			tx_sr <= '1;
			tx_cnt <= 6'h00;
			wcnt <= 7'h00;
			rx_sr <= '0;
			rx_cnt <= 8'h00;
			rx_len <= 8'h00;
			rca_next <= 16'h0001;
			card_count <= 16'h0000;
			ocr_seen <= 32'h0;
			done <= 1'b0;
		end
		else
		begin
			ph <= next_ph;
			seq <= next_seq;
			div_cnt <= next_div_cnt;
			mclk <= next_mclk;
			drv <= next_drv;
			bit_o <= next_bit_o;
			tx_sr <= next_tx_sr;
			tx_cnt <= next_tx_cnt;
			wcnt <= next_wcnt;
			rx_sr <= next_rx_sr;
			rx_cnt <= next_rx_cnt;
			rx_len <= next_rx_len;
			rca_next <= next_rca_next;
			card_count <= next_card_count;
			ocr_seen <= next_ocr_seen;
			done <= next_done;
		end
	end

	assign running = (ph != h_idle);
	assign bus.mclk = mclk;
	assign bus.cmd_h_o = bit_o;
	// open drain throughout identification, lines only pulled low
	assign bus.cmd_h_oe_n = ~(drv & ~bit_o);
endmodule
`default_nettype wire

// [verif/mmc_link_asserts.sv]
`timescale 1ns/100ps
`default_nettype none
// ----------------
// link wire checks
// ----------------
module mmc_link_asserts
#(
	parameter int MCLK_HALF = 8
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic mclk,
	input wire logic cmd_h_o,
	input wire logic cmd_h_oe_n,
	input wire logic cmd_c_o,
	input wire logic cmd_c_oe_n,
	input wire logic dat_c_oe_n,
	input wire logic cmd_line
);
	logic mclk_q;
	logic next_mclk_q;
	logic [15:0] run;
	logic [15:0] next_run;
	logic [15:0] quiet;
	logic [15:0] next_quiet;
	// run: cycles since the link clock moved; quiet: cycles card released
	always_comb
	begin
		next_mclk_q = mclk;
		next_run = run + {15'h0000, run != 16'hFFFF};
		if (mclk != mclk_q)
			next_run = 16'h0000;
		next_quiet = 16'h0000;
		if (cmd_c_oe_n)
			next_quiet = quiet + {15'h0000, quiet != 16'hFFFF};
	end
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			mclk_q <= 1'b0;
			run <= 16'h0000;
			quiet <= 16'h0000;
		end
		else
		begin
			mclk_q <= next_mclk_q;
			run <= next_run;
			quiet <= next_quiet;
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	// a reply opens with two low bits: start, then direction
	sequence s_zero_bit;
		(!cmd_c_oe_n && !cmd_c_o)[*8];
	endsequence
	sequence s_dir_bit;
		!cmd_c_oe_n && !cmd_c_o;
	endsequence
	a_dat_released: assert property (dat_c_oe_n)
		else $error("card drove a data line");
	a_host_open_drain: assert property
		(!cmd_h_oe_n |-> !cmd_h_o && !cmd_line)
		else $error("host drove a high level");
	a_mclk_high_span: assert property
		($fell(mclk) |-> run == MCLK_HALF - 1)
		else $error("link clock high phase wrong");
	a_no_contention: assert property
		(!cmd_h_oe_n |-> cmd_c_oe_n)
		else $error("card drove during a command");
	a_answer_delay: assert property
		($rose(cmd_h_oe_n) |-> cmd_c_oe_n[*8])
		else $error("card answered too soon");
	a_card_bit_hold: assert property
		(mclk && $past(mclk) |-> $stable(cmd_c_o) && $stable(cmd_c_oe_n))
		else $error("card bit moved while clock high");
	a_host_bit_hold: assert property
		(mclk && $past(mclk) |-> $stable(cmd_h_oe_n))
		else $error("host bit moved while clock high");
	a_reply_start: assert property
		($fell(cmd_c_oe_n) && quiet > 16'h012C |-> s_zero_bit ##16 s_dir_bit)
		else $error("reply lacks start and direction bits");
endmodule
`default_nettype wire

// [verif/testbench.sv]
`timescale 1ns/100ps
`default_nettype none
`include "mmc_id_regs.svh"
// ---------------------
// identification bench
// ---------------------
module testbench
	import mmc_id_pkg::*;
;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic start = 1'b0;
	logic [23:0] win = 24'hFF8000;
	logic [127:0] cid_a = 128'hA5A5_0F0F_1234_5678_9ABC_DEF0_0246_8ACE;
	logic [127:0] cid_b = 128'h8123_4567_89AB_CDEF_0123_4567_89AB_CDEF;
	card_state_e st_a;
	card_state_e st_b;
	logic [15:0] rca_a;
	logic [15:0] rca_b;
	logic [15:0] count;
	logic [31:0] ocr_seen;
	logic ill_b;
	logic busy_b;
	logic done;
	logic running;
	logic s;
	logic pp;
	logic [135:0] r;
	int err_total = 0;
	int comparisons = 0;
	mmc_bus bus1();
	mmc_bus bus2();
	// bench plays the host on the second link
	initial
	begin
		bus2.mclk = 1'b0;
		bus2.cmd_h_o = 1'b0;
		bus2.cmd_h_oe_n = 1'b1;
	end
	always #5 clk = ~clk;
	mmc_host #(.MCLK_HALF(8)) mmc_host_inst(.clk(clk), .rst(rst), .bus(bus1),
		.start(start), .ocr_window(win), .running(running), .done(done),
		.card_count(count), .ocr_seen(ocr_seen));
	mmc_card mmc_card_inst(.clk(clk), .rst(rst), .bus(bus1), .cid(cid_a),
		.state(st_a), .rca(rca_a), .illegal_cmd(), .busy());
	// power-up must outlast the whole busy query, command and reply included
	mmc_card #(.POWERUP_CYC(3000)) mmc_card_inst_b(.clk(clk), .rst(rst),
		.bus(bus2), .cid(cid_b), .state(st_b), .rca(rca_b),
		.illegal_cmd(ill_b), .busy(busy_b));
	mmc_link_asserts #(.MCLK_HALF(8)) mmc_link_asserts_inst(.clk(clk),
		.rst(rst), .mclk(bus1.mclk), .cmd_h_o(bus1.cmd_h_o),
		.cmd_h_oe_n(bus1.cmd_h_oe_n), .cmd_c_o(bus1.cmd_c_o),
		.cmd_c_oe_n(bus1.cmd_c_oe_n), .dat_c_oe_n(bus1.dat_c_oe_n),
		.cmd_line(bus1.cmd_line));
	task check(input logic ok, input string msg);
		comparisons++;
		if (ok !== 1'b1)
		begin
			err_total++;
			$display("Error at %0t: %s", $time, msg);
		end
	endtask
	// one link period; bit 1 means released, line read late in high phase
	task per(input logic b);
		bus2.mclk <= 1'b0;
		bus2.cmd_h_oe_n <= b;
		repeat (8) @(posedge clk);
		bus2.mclk <= 1'b1;
		repeat (8) @(posedge clk);
		s = bus2.cmd_line;
		if (!bus2.cmd_c_oe_n && bus2.cmd_c_o)
			pp = 1'b1;
	endtask
	task send(input logic [5:0] idx, input logic [31:0] arg);
		logic [47:0] f;
		f = {2'b01, idx, arg, 7'h00, 1'b1};
		for (int i = 47; i >= 0; i--)
			per(f[i]);
	endtask
	// bench pulls the line low at bit kill to beat the card
	task recv(input int n, input int kill, input logic want);
		logic got;
		got = 1'b0;
		pp = 1'b0;
		r = '0;
		for (int i = 0; i < 16 && !got; i++)
		begin
			per(1'b1);
			got = !s;
		end
		check(got === want, "reply presence");
		for (int j = 1; j < n && got; j++)
		begin
			per(j != kill);
			r = {r[134:0], s};
		end
		repeat (8) per(1'b1);
	endtask
	task wait_done;
		for (int i = 0; i < 40000 && done !== 1'b1; i++)
			@(posedge clk);
		check(done === 1'b1, "no done");
	endtask
	task t_busy;
		send(`CMD_OP_COND, 32'h0);
		recv(48, 0, 1'b1);
		check(r[47:0] === {8'h3F, 32'h00FF8000, 8'hFF}, "busy reply");
		check(st_b === st_idle && busy_b === 1'b1, "query moved");
		$display("t_busy done");
	endtask
	task t_reserved;
		logic [5:0] tbl [18] = '{6'h05, 6'h06, 6'h08, 6'h0E, 6'h13, 6'h15,
			6'h16, 6'h1F, 6'h27, 6'h28, 6'h29, 6'h2B, 6'h36, 6'h38, 6'h38,
			6'h39, 6'h3F, 6'h37};
		for (int i = 0; i < 18; i++)
		begin
			send(tbl[i], {31'h0, i[0]});
			recv(48, 0, 1'b0);
			check(ill_b === 1'b1 && st_b === st_idle, "index taken");
		end
		send(`CMD_OP_COND, 32'h00FF8000);
		recv(48, 0, 1'b1);
		check(r[47:0] === {8'h3F, 32'h80FF8000, 8'hFF}, "ready reply");
		check(st_b === st_ready && ill_b === 1'b0, "not ready");
		$display("t_reserved done");
	endtask
	task t_arb;
		send(`CMD_ALL_CID, 32'h0);
		recv(136, 8, 1'b1);
		check(r[126:0] === {127{1'b1}} && st_b === st_ready, "loser");
		check(pp === 1'b0, "drove high");
		send(`CMD_ALL_CID, 32'h0);
		recv(136, 0, 1'b1);
		check(r === {8'h3F, cid_b[127:1], 1'b1}, "identity");
		check(st_b === st_ident && pp === 1'b0, "winner");
		$display("t_arb done");
	endtask
	task t_rca;
		send(`CMD_SET_RCA, 32'h00050000);
		recv(48, 0, 1'b1);
		check(r[47:40] === 8'h03 && r[30] === 1'b0 && r[20:17] === 4'h2, "R1");
		check(st_b === st_stby && rca_b === 16'h0005, "standby");
		check(pp === 1'b1, "still open drain");
		send(`CMD_ALL_CID, 32'h0);
		recv(136, 0, 1'b0);
		check(st_b === st_stby, "left standby");
		$display("t_rca done");
	endtask
	task t_host;
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		@(posedge clk);
		check(running === 1'b1, "host not running");
		wait_done();
		check(running === 1'b0, "host still running");
		check(count === 16'h0001 && ocr_seen === 32'h80FF8000, "count");
		check(st_a === st_stby && rca_a === 16'h0001, "card a");
		$display("t_host done");
	endtask
	task t_inactive;
		rst <= 1'b1;
		win <= 24'h000100;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_host_start();
		wait_done();
		check(st_a === st_inactive && count === 16'h0000, "range");
		$display("t_inactive done");
	endtask
	task t_host_start;
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
	endtask
	task summarize;
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// main sequence: both links run side by side after reset
	initial
	begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		fork
			t_host();
			begin
				t_busy();
				t_reserved();
				t_arb();
				t_rca();
			end
		join
		t_inactive();
		summarize();
	end
	// watchdog well beyond the expected run
	initial
	begin
		repeat (60000) @(posedge clk);
		err_total++;
		$display("Error at %0t: timeout", $time);
		summarize();
	end
endmodule
`default_nettype wire
